// >>> inc/pmps_pkg.sv
// Constants, register map and state codes of the power sequencer
package pmps_pkg;

  // ****************************************
  // Rails
  // ****************************************
  localparam int unsigned NRAIL = 10;
  localparam int unsigned NSEQ  = 8;
  localparam int unsigned NDLY  = 9;
  localparam logic [3:0]  NSTEP = 4'ha;
  localparam logic [3:0]  STEP3 = 4'h3;
  localparam int unsigned R_BKA = 4;
  localparam int unsigned R_BKB = 5;
  localparam int unsigned R_LS2 = 8;
  localparam int unsigned R_LS3 = 9;
  // Rails forced off at down start when unsequenced
  localparam logic [7:0]  EARLY_OFF = 8'hcf;

  // ****************************************
  // Register offsets and fields
  // ****************************************
  localparam logic [7:0] A_EN   = 8'h00;
  localparam logic [7:0] A_SEQ  = 8'h01;
  localparam logic [7:0] A_DLY  = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h20;
  localparam logic [7:0] A_STAT = 8'h21;
  localparam int unsigned C_MUL  = 0;
  localparam int unsigned C_HOLD = 1;
  localparam int unsigned C_LONG = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [9:0]  EN_RST   = 10'h000;
  localparam logic [9:0]  DCH_RST  = 10'h3ff;
  localparam logic [31:0] SEQ_RST  = 32'h87216543;
  localparam logic [1:0]  DLY_RST  = 2'h0;
  localparam logic [2:0]  CTRL_RST = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_NS        = 25;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_NS;
  localparam logic [6:0]  DLY_MIN_MS    = 7'h02;
  localparam logic [6:0]  DOWN_FACTOR   = 7'h0a;
  localparam logic [14:0] DOWN_TOTAL_MS = 15'h01f4;
  localparam logic [14:0] DCH_MIN_MS    = 15'h0096;
  localparam logic [14:0] AWAIT_MS      = 15'h4e20;
  localparam logic [13:0] PRESS_MS      = 14'h1f40;
  localparam logic [13:0] PRESS_LONG_MS = 14'h3a98;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [6:0] {
    ST_OFF    = 7'h01,
    ST_PRE    = 7'h02,
    ST_AWAIT  = 7'h04,
    ST_ACTIVE = 7'h08,
    ST_SUSP   = 7'h10,
    ST_RECOV  = 7'h20,
    ST_DOWN   = 7'h40
  } pmps_state_t;

endpackage

// >>> core/pmps_sequencer.sv
// Power state machine and rail step sequencer
//
// Behaviour
// [RQ1] Ten steps, nine delays of 2-5 ms
// [RQ2] One step field per rail, steps shared; only rails 0-7 have one, rails 8 and 9 none
// [RQ3] Up: fire step, wait delay, next step
// [RQ4] Off: button, adapter, enable, power start up
// [RQ5] Pre-off: button, adapter, enable start up
// [RQ6] Suspend: edges or enable level start up
// [RQ7] Await enable; 20 s idle powers down
// [RQ8] Enable high moves to active state
// [RQ9] Step field zero leaves rail untouched
// [RQ10] Enable register writes refused while sequencing
// [RQ11] Enable bits show real rail state
// [RQ12] Down: step ten first, reverse order
// [RQ13] Down delays stretched tenfold, multiplier global
// [RQ14] Leave power-down exactly 500 ms after start
// [RQ15] Enable low or fault starts power-down
// [RQ16] Long press 8 s or 15 s powers down
// [RQ17] Suspend keeps unsequenced rails as they were
// [RQ18] Unsequenced main rails off at down start
// [RQ19] Switches two, three off at down end
// [RQ20] Core reset: all rails off, discharging
// [RQ21] Steps one, two serve backup rails only
// [RQ22] Backup hold skips steps two and one
// [RQ23] Rail supervision fault drops rails good
// [RQ24] Rails good low when down triggered
`timescale 1ns/1ps
module pmps_sequencer #(
  parameter int unsigned CYC_PER_MS = pmps_pkg::CYC_PER_MS
) (
  input  wire logic        i_mclk,  // 40 MHz clock
  input  wire logic        i_rst,   // Bias collapse reset
  input  wire logic        i_pb,    // Push button, low pressed
  input  wire logic        i_ac,    // Adapter detect
  input  wire logic        i_en,    // Host enable
  input  wire logic        i_mpwr,  // Main power present
  input  wire logic        i_undervoltage_lockout,  // Undervoltage lockout
  input  wire logic        i_ots,   // Thermal shutdown
  input  wire logic        i_rfail, // Rail supervision fault
  input  wire logic [7:0]  i_addr,  // Register address
  input  wire logic [15:0] i_wdata, // Write data
  input  wire logic        i_wr,    // Write strobe
  input  wire logic        i_rd,    // Read strobe
  output logic      [15:0] o_rdata, // Read data
  output logic      [9:0]  o_rail,  // Rail enables
  output logic      [9:0]  o_dch,   // Discharge enables
  output logic             o_rails_good_output, // Rails good
  output logic             o_busy   // Sequencer running
);

  // ****************************************
  // Registers
  // ****************************************
  pmps_pkg::pmps_state_t st_q;
  pmps_pkg::pmps_state_t st_d;
  pmps_pkg::pmps_state_t tgt_q;
  pmps_pkg::pmps_state_t tgt_d;
  logic [3:0]  seq_q [pmps_pkg::NSEQ];
  logic [1:0]  dly_q [pmps_pkg::NDLY];
  logic [2:0]  ctrl_q;
  logic [9:0]  rail_q;
  logic [9:0]  dch_q;
  logic [15:0] rdata_q;
  logic        pg_q;
  logic        run_q;
  logic        dir_q;
  logic [3:0]  step_q;
  logic [6:0]  cnt_q;
  logic [15:0] pre_q;
  logic [14:0] tmr_q;
  logic [13:0] press_q;
  logic        pb_q;
  logic        ac_q;
  logic        en_q;
  logic        mp_q;
  logic        tick;
  logic        busy;
  logic        fire;
  logic        last;
  logic        up_go;
  logic        dn_go;
  logic        fault;
  logic        okay;
  logic        longp;
  logic        dn_end;
  logic [6:0]  nxt_ms;
  logic [3:0]  nidx;
  logic [7:0]  hit;
  logic [9:0]  wr_en;

  // ****************************************
  // Register bus
  // ****************************************
  assign wr_en = i_wdata[9:0];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_q <= pmps_pkg::CTRL_RST;
      for (int i = 0; i < pmps_pkg::NSEQ; i++) begin
        seq_q[i] <= pmps_pkg::SEQ_RST[4*i +: 4];
      end
      for (int i = 0; i < pmps_pkg::NDLY; i++) begin
        dly_q[i] <= pmps_pkg::DLY_RST;
      end
    end else if (i_wr) begin
      if (i_addr == pmps_pkg::A_CTRL) begin
        ctrl_q <= i_wdata[2:0];
      end
      for (int i = 0; i < pmps_pkg::NSEQ; i++) begin
        if (i_addr == pmps_pkg::A_SEQ + 8'(i)) begin
          seq_q[i] <= i_wdata[3:0]; // see [RQ2]
        end
      end
      for (int i = 0; i < pmps_pkg::NDLY; i++) begin
        if (i_addr == pmps_pkg::A_DLY + 8'(i)) begin
          dly_q[i] <= i_wdata[1:0];
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          pmps_pkg::A_EN: begin
            rdata_q <= {6'h00, rail_q}; // see [RQ11]
          end
          pmps_pkg::A_CTRL: begin
            rdata_q <= {13'h0000, ctrl_q};
          end
          pmps_pkg::A_STAT: begin
            rdata_q <= {7'h00, busy, pg_q, st_q};
          end
          default: begin
            for (int i = 0; i < pmps_pkg::NSEQ; i++) begin
              if (i_addr == pmps_pkg::A_SEQ + 8'(i)) begin
                rdata_q <= {12'h000, seq_q[i]};
              end
            end
            for (int i = 0; i < pmps_pkg::NDLY; i++) begin
              if (i_addr == pmps_pkg::A_DLY + 8'(i)) begin
                rdata_q <= {14'h0000, dly_q[i]};
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Inputs and timers
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pb_q <= 1'b1;
      ac_q <= 1'b1;
      en_q <= 1'b0;
      mp_q <= 1'b0;
    end else begin
      pb_q <= i_pb;
      ac_q <= i_ac;
      en_q <= i_en;
      mp_q <= i_mpwr;
    end
  end

  // Millisecond prescaler, realigned at each sequence start
  assign tick = (pre_q == 16'(CYC_PER_MS - 1));

  always_ff @(posedge i_mclk) begin
    if (i_rst || up_go || dn_go || tick) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || st_d != st_q) begin
      tmr_q <= 15'h0000;
    end else if (tick && tmr_q != 15'h7fff) begin
      tmr_q <= tmr_q + 15'h0001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_pb) begin
      press_q <= 14'h0000;
    end else if (tick && press_q != 14'h3fff) begin
      press_q <= press_q + 14'h0001;
    end
  end

  // ****************************************
  // Events
  // ****************************************
  assign okay  = !i_undervoltage_lockout && !i_ots;
  assign fault = i_undervoltage_lockout || i_ots || i_rfail; // see [RQ15] see [RQ23]
  assign longp = !i_pb && (press_q >= (ctrl_q[pmps_pkg::C_LONG] ?
                 pmps_pkg::PRESS_LONG_MS : pmps_pkg::PRESS_MS)); // see [RQ16]
  assign dn_end = (st_q == pmps_pkg::ST_DOWN) && tick &&
                  (tmr_q == pmps_pkg::DOWN_TOTAL_MS - 15'h0001); // see [RQ14]

  always_comb begin
    st_d  = st_q;
    tgt_d = tgt_q;
    up_go = 1'b0;
    dn_go = 1'b0;
    case (st_q)
      pmps_pkg::ST_OFF: begin
        if (okay && ((pb_q && !i_pb) || (ac_q && !i_ac) || (!en_q && i_en) ||
            (!mp_q && i_mpwr && !i_ac))) begin // see [RQ4]
          up_go = 1'b1;
        end
      end
      pmps_pkg::ST_PRE: begin
        if (okay && ((pb_q && !i_pb) || (ac_q && !i_ac) || (!en_q && i_en))) begin // see [RQ5]
          up_go = 1'b1;
        end
      end
      pmps_pkg::ST_RECOV: begin
        if (!fault) begin
          st_d = pmps_pkg::ST_PRE;
        end
      end
      pmps_pkg::ST_DOWN: begin
        if (dn_end) begin
          st_d = tgt_q;
        end
      end
      pmps_pkg::ST_SUSP, pmps_pkg::ST_AWAIT, pmps_pkg::ST_ACTIVE: begin
        dn_go = 1'b1;
        if (fault) begin
          tgt_d = pmps_pkg::ST_RECOV; // see [RQ15]
        end else if (longp) begin
          tgt_d = pmps_pkg::ST_OFF; // see [RQ16]
        end else if (st_q == pmps_pkg::ST_AWAIT && i_pb && i_ac && !i_en &&
                     tmr_q >= pmps_pkg::AWAIT_MS) begin
          tgt_d = pmps_pkg::ST_OFF; // see [RQ7]
        end else if (st_q == pmps_pkg::ST_ACTIVE && !i_en) begin
          tgt_d = pmps_pkg::ST_SUSP; // see [RQ15]
        end else begin
          dn_go = 1'b0;
          if (st_q == pmps_pkg::ST_AWAIT && i_en) begin
            st_d = pmps_pkg::ST_ACTIVE; // see [RQ8]
          end else if (st_q == pmps_pkg::ST_SUSP &&
                       ((pb_q && !i_pb) || (ac_q && !i_ac) || i_en)) begin // see [RQ6]
            up_go = 1'b1;
          end
        end
      end
      default: begin
        st_d = pmps_pkg::ST_OFF;
      end
    endcase
    if (up_go) begin
      st_d = pmps_pkg::ST_AWAIT; // see [RQ7]
    end
    if (dn_go) begin
      st_d = pmps_pkg::ST_DOWN;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q  <= pmps_pkg::ST_OFF;
      tgt_q <= pmps_pkg::ST_OFF;
    end else begin
      st_q  <= st_d;
      tgt_q <= tgt_d;
    end
  end

  // ****************************************
  // Step sequencer
  // ****************************************
  assign busy = run_q || (st_q == pmps_pkg::ST_DOWN);
  assign fire = run_q && (cnt_q == 7'h00) && !dn_go;
  assign last = dir_q ? (step_q == (ctrl_q[pmps_pkg::C_HOLD] ?
                pmps_pkg::STEP3 : 4'h1)) : (step_q == pmps_pkg::NSTEP); // see [RQ22]
  assign nidx = dir_q ? step_q - 4'h2 : step_q - 4'h1;

  always_comb begin
    nxt_ms = 7'({5'h00, dly_q[nidx]}) + pmps_pkg::DLY_MIN_MS; // see [RQ1]
    if (dir_q) begin
      nxt_ms = 7'(nxt_ms * pmps_pkg::DOWN_FACTOR); // see [RQ13]
      if (ctrl_q[pmps_pkg::C_MUL]) begin
        nxt_ms = 7'({nxt_ms, 1'b0});
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      run_q  <= 1'b0;
      dir_q  <= 1'b0;
      step_q <= 4'h0;
      cnt_q  <= 7'h00;
    end else if (dn_go) begin
      run_q  <= 1'b1;
      dir_q  <= 1'b1;
      step_q <= pmps_pkg::NSTEP; // see [RQ12]
      cnt_q  <= 7'h00;
    end else if (up_go) begin
      run_q  <= 1'b1;
      dir_q  <= 1'b0;
      step_q <= 4'h1; // see [RQ3]
      cnt_q  <= 7'h00;
    end else if (fire) begin
      run_q  <= !last;
      step_q <= dir_q ? step_q - 4'h1 : step_q + 4'h1; // see [RQ3] see [RQ12]
      cnt_q  <= nxt_ms;
    end else if (run_q && tick) begin
      cnt_q <= cnt_q - 7'h01;
    end
  end

  // Per rail step match; backup rails only on steps 1 and 2
  for (genvar g = 0; g < pmps_pkg::NSEQ; g++) begin : g_hit
    if (g == pmps_pkg::R_BKA || g == pmps_pkg::R_BKB) begin : g_bk
      assign hit[g] = fire && (seq_q[g] == step_q) && (step_q <= 4'h2); // see [RQ21]
    end else begin : g_main
      assign hit[g] = fire && (seq_q[g] == step_q) && (step_q > 4'h2); // see [RQ21] see [RQ9]
    end
  end

  // ****************************************
  // Rail enables and discharge
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rail_q <= pmps_pkg::EN_RST; // see [RQ20]
      dch_q  <= pmps_pkg::DCH_RST;
    end else begin
      if (i_wr && i_addr == pmps_pkg::A_EN && !busy) begin // see [RQ10]
        rail_q <= wr_en;
        dch_q  <= dch_q & ~wr_en;
      end
      if (up_go) begin
        dch_q <= 10'h000;
      end
      for (int i = 0; i < pmps_pkg::NSEQ; i++) begin
        if (hit[i]) begin
          rail_q[i] <= !dir_q; // see [RQ11]
          dch_q[i]  <= dir_q;
        end
        if (dn_go && tgt_d != pmps_pkg::ST_SUSP && pmps_pkg::EARLY_OFF[i] &&
            seq_q[i] == 4'h0) begin // see [RQ18] see [RQ17]
          rail_q[i] <= 1'b0;
          dch_q[i]  <= 1'b1;
        end
      end
      if (dn_end && tgt_q != pmps_pkg::ST_SUSP) begin // see [RQ19]
        rail_q[pmps_pkg::R_LS3:pmps_pkg::R_LS2] <= 2'h0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || dn_go || st_q == pmps_pkg::ST_SUSP) begin
      pg_q <= 1'b0; // see [RQ24] see [RQ23]
    end else if (fire && !dir_q && last) begin
      pg_q <= 1'b1;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rail  = rail_q;
  assign o_dch   = dch_q;
  assign o_rails_good_output = pg_q;
  assign o_busy  = busy;

  // ****************************************
  // Checks
  // ****************************************
  AST_RESET_OFF: assert property (@(posedge i_mclk) i_rst |=> (o_rail == 10'h000 && o_dch == 10'h3ff)) // see [RQ20]
    else $error("Rails not off after core reset");
  AST_WR_REFUSED: assert property (@(posedge i_mclk) disable iff (i_rst)
    (busy && i_wr && i_addr == pmps_pkg::A_EN && !fire && !dn_go && !dn_end) |=> $stable(o_rail)) // see [RQ10]
    else $error("Enable write taken while sequencing");
  AST_WR_TAKEN: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!busy && i_wr && i_addr == pmps_pkg::A_EN && !up_go && !dn_go) |=> o_rail == $past(wr_en)) // see [RQ11]
    else $error("Enable write lost");
  AST_PG_DROP: assert property (@(posedge i_mclk) disable iff (i_rst) dn_go |=> !o_rails_good_output) // see [RQ24]
    else $error("Rails good high after down trigger");
  AST_FAULT_DOWN: assert property (@(posedge i_mclk) disable iff (i_rst)
    (fault && (st_q == pmps_pkg::ST_AWAIT || st_q == pmps_pkg::ST_ACTIVE))
    |=> (st_q == pmps_pkg::ST_DOWN && tgt_q == pmps_pkg::ST_RECOV)) // see [RQ15]
    else $error("Fault did not start power-down");
  AST_ACTIVE: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == pmps_pkg::ST_AWAIT && i_en && !fault && !longp) |=> st_q == pmps_pkg::ST_ACTIVE) // see [RQ8]
    else $error("Enable did not reach active");
  AST_DOWN_EXIT: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == pmps_pkg::ST_DOWN && tmr_q == pmps_pkg::DOWN_TOTAL_MS && tick) |-> 1'b0) // see [RQ14]
    else $error("Power-down ran past its end");
  AST_DOWN_MIN: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == pmps_pkg::ST_DOWN && st_d != pmps_pkg::ST_DOWN) |-> tmr_q >= pmps_pkg::DCH_MIN_MS) // see [RQ14]
    else $error("Power-down left too early");
  AST_LS_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == pmps_pkg::ST_DOWN && !dn_end) |=> $stable(o_rail[pmps_pkg::R_LS3:pmps_pkg::R_LS2])) // see [RQ19]
    else $error("Load switch two or three moved during power-down");
  AST_BK_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st_q == pmps_pkg::ST_DOWN && dir_q && ctrl_q[pmps_pkg::C_HOLD] && !i_wr)
    |=> $stable(o_rail[pmps_pkg::R_BKB:pmps_pkg::R_BKA])) // see [RQ22]
    else $error("Backup rails moved under hold");
  AST_UNTOUCHED: assert property (@(posedge i_mclk) disable iff (i_rst)
    (fire && seq_q[6] == 4'h0) |=> o_rail[6] == $past(o_rail[6])) // see [RQ9]
    else $error("Unassigned rail changed by a step");
  AST_FIRST_STEP: assert property (@(posedge i_mclk) disable iff (i_rst)
    (dn_go && !up_go) |=> (fire && step_q == pmps_pkg::NSTEP)) // see [RQ12]
    else $error("Power-down did not begin at step ten");

endmodule

// >>> testbench/pmps_host_model.sv
// Host side model: push button, adapter detect, host enable, main power
`timescale 1ns/1ps
module pmps_host_model (
  input  wire logic i_mclk, // Clock
  output logic      o_pb,   // Push button, low pressed
  output logic      o_ac,   // Adapter detect, low attached
  output logic      o_en,   // Host enable
  output logic      o_mpwr  // Main power present
);
  initial begin
    o_pb   = 1'b1;
    o_ac   = 1'b1;
    o_en   = 1'b0;
    o_mpwr = 1'b0;
  end

  // Pins move just after a rising edge and then hold
  task automatic drive(input logic pb, input logic ac, input logic en, input logic mp);
    @(posedge i_mclk);
    o_pb   <= pb;
    o_ac   <= ac;
    o_en   <= en;
    o_mpwr <= mp;
  endtask
endmodule

// >>> testbench/tb_pmps_sequencer.sv
// Self-checking bench of the power sequencer
`timescale 1ns/1ps
module tb_pmps_sequencer;
  localparam int unsigned CPM   = 2;
  localparam int unsigned LIMIT = 80000;
  logic        i_mclk, i_rst, i_undervoltage_lockout, i_ots, i_rfail, i_wr, i_rd;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic [9:0]  o_rail, o_dch;
  logic        o_rails_good_output, o_busy, pb, ac, en, mpwr;
  int          failures, n_checks, cycles, n, t0;
  logic [15:0] d;

  initial i_mclk = 1'b0;
  always #12.5 i_mclk = ~i_mclk;

  pmps_host_model host_u (.i_mclk(i_mclk), .o_pb(pb), .o_ac(ac), .o_en(en), .o_mpwr(mpwr));

  pmps_sequencer #(.CYC_PER_MS(CPM)) dut_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_pb(pb), .i_ac(ac), .i_en(en), .i_mpwr(mpwr),
    .i_undervoltage_lockout(i_undervoltage_lockout), .i_ots(i_ots), .i_rfail(i_rfail), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rail(o_rail), .o_dch(o_dch),
    .o_rails_good_output(o_rails_good_output), .o_busy(o_busy));

  // ****************************************
  // Checks and bus cycles
  // ****************************************
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input int got, input int exp, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic state_is(input logic [6:0] s);
    rd(pmps_pkg::A_STAT, d);
    chk({9'h000, d[6:0]}, {9'h000, s});
  endtask

  task automatic wait_busy(input logic v);
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (o_busy !== v && n < 50000);
  endtask

  task automatic wait_rail();
    logic [9:0] prev;
    prev = o_rail;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (o_rail === prev && n < 5000);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk({6'h00, o_rail}, 16'h0000);
    chk({6'h00, o_dch}, 16'h03ff);
    chk({15'h0000, o_rails_good_output}, 16'h0000);
    state_is(pmps_pkg::ST_OFF);
    rd(pmps_pkg::A_SEQ, d);
    chk(d, 16'h0003);
    rd(8'h30, d);
    chk(d, 16'h0000);
  endtask

  task automatic t_up_button();
    host_u.drive(1'b0, 1'b1, 1'b0, 1'b0);
    host_u.drive(1'b1, 1'b1, 1'b0, 1'b0);
    wait_rail();
    chk({6'h00, o_rail}, 16'h0010);
    wait_rail();
    chk({6'h00, o_rail}, 16'h0030);
    chk_near(n, 2 * CPM, 1);
    wait_rail();
    chk({6'h00, o_rail}, 16'h0031);
    wr(pmps_pkg::A_EN, 16'h03ff);
    state_is(pmps_pkg::ST_AWAIT);
    wait_busy(1'b0);
    chk({6'h00, o_rail}, 16'h00ff);
    chk({15'h0000, o_rails_good_output}, 16'h0001);
    chk({6'h00, o_dch}, 16'h0000);
    host_u.drive(1'b1, 1'b1, 1'b1, 1'b0);
    host_u.drive(1'b1, 1'b0, 1'b1, 1'b0);
    state_is(pmps_pkg::ST_ACTIVE);
    host_u.drive(1'b1, 1'b1, 1'b1, 1'b0);
    wr(pmps_pkg::A_EN, 16'h01ff);
    chk({6'h00, o_rail}, 16'h01ff);
    rd(pmps_pkg::A_EN, d);
    chk(d, 16'h01ff);
  endtask

  task automatic t_down_suspend();
    wr(pmps_pkg::A_CTRL, 16'h0002);
    wr(pmps_pkg::A_SEQ + 8'h06, 16'h0000);
    t0 = cycles;
    host_u.drive(1'b1, 1'b1, 1'b0, 1'b0);
    state_is(pmps_pkg::ST_DOWN);
    chk({15'h0000, o_rails_good_output}, 16'h0000);
    wait_rail();
    chk({6'h00, o_rail}, 16'h017f);
    chk_near(cycles - t0, 40 * CPM, 4);
    wait_rail();
    chk({6'h00, o_rail}, 16'h0177);
    chk_near(n, 40 * CPM, 2);
    wait_busy(1'b0);
    chk_near(cycles - t0, 500 * CPM, 4);
    chk({6'h00, o_rail}, 16'h0170);
    chk({6'h00, o_dch & 10'h08f}, 16'h008f);
    state_is(pmps_pkg::ST_SUSP);
  endtask

  task automatic t_fault();
    host_u.drive(1'b1, 1'b1, 1'b1, 1'b0);
    wait_busy(1'b0);
    chk({6'h00, o_rail}, 16'h01ff);
    state_is(pmps_pkg::ST_ACTIVE);
    @(posedge i_mclk);
    i_rfail <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    chk({6'h00, o_rail}, 16'h01bf);
    chk({15'h0000, o_rails_good_output}, 16'h0000);
    wait_busy(1'b0);
    chk({6'h00, o_rail}, 16'h0030);
    state_is(pmps_pkg::ST_RECOV);
    @(posedge i_mclk);
    i_rfail <= 1'b0;
    i_ots   <= 1'b1;
    repeat (3) @(posedge i_mclk);
    state_is(pmps_pkg::ST_RECOV);
    @(posedge i_mclk);
    i_ots <= 1'b0;
    repeat (3) @(posedge i_mclk);
    state_is(pmps_pkg::ST_PRE);
  endtask

  task automatic t_pre_timeout();
    host_u.drive(1'b1, 1'b1, 1'b0, 1'b0);
    t0 = cycles;
    host_u.drive(1'b1, 1'b0, 1'b0, 1'b0);
    wait_busy(1'b0);
    chk({6'h00, o_rail}, 16'h00bf);
    state_is(pmps_pkg::ST_AWAIT);
    host_u.drive(1'b1, 1'b1, 1'b0, 1'b0);
    wait_busy(1'b1);
    chk_near(cycles - t0, 20000 * CPM, 4);
    wait_busy(1'b0);
    state_is(pmps_pkg::ST_OFF);
    chk({6'h00, o_rail}, 16'h0030);
  endtask

  task automatic t_lockout_press();
    @(posedge i_mclk);
    i_undervoltage_lockout <= 1'b1;
    host_u.drive(1'b0, 1'b0, 1'b0, 1'b0);
    host_u.drive(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge i_mclk);
    state_is(pmps_pkg::ST_OFF);
    @(posedge i_mclk);
    i_undervoltage_lockout <= 1'b0;
    host_u.drive(1'b1, 1'b0, 1'b0, 1'b1);
    wait_busy(1'b0);
    state_is(pmps_pkg::ST_AWAIT);
    t0 = cycles;
    host_u.drive(1'b0, 1'b0, 1'b0, 1'b1);
    wait_busy(1'b1);
    chk_near(cycles - t0, 8000 * CPM, 4);
  endtask

  initial begin
    failures = 0;
    n_checks = 0;
    cycles   = 0;
    i_rst    = 1'b1;
    i_undervoltage_lockout   = 1'b0;
    i_ots    = 1'b0;
    i_rfail  = 1'b0;
    i_wr     = 1'b0;
    i_rd     = 1'b0;
    i_addr   = 8'h00;
    i_wdata  = 16'h0000;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    t_reset();
    t_up_button();
    t_down_suspend();
    t_fault();
    t_pre_timeout();
    t_lockout_press();
    print_verdict();
  end
endmodule
